// *** verilog/spc_defines.svh ***
// Constants for the servo protection and current-limit block
// Assumes inclusion by bare name from the package and the modules
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// APB byte addresses, one 32-bit word each
`define SPC_ADDR_PARAM 8'h00
`define SPC_ADDR_LIMIT 8'h04
`define SPC_ADDR_CURRENT 8'h08
`define SPC_ADDR_BRAKE 8'h0c
`define SPC_ADDR_STATUS 8'h10
`define SPC_ADDR_POSITION 8'h14
`define SPC_ADDR_IRQ_STAT 8'h18
`define SPC_ADDR_IRQ_CLR 8'h1c
`define SPC_ADDR_IRQ_EN 8'h20

// Field positions
`define SPC_F_ORG_LSB 0
`define SPC_F_FMT 4
`define SPC_F_SON_METHOD 5
`define SPC_F_SON_REQ 8
`define SPC_F_OVF_LSB 0
`define SPC_F_TRK_LSB 16
`define SPC_F_RUN_LSB 0
`define SPC_F_STOP_LSB 4
`define SPC_F_BOOST_LSB 8
`define SPC_F_RATIO_LSB 16

// Reset values: origin 0, signed count, fast servo-on, limits 5000 pulses,
// run 10, stop 5, boost 0, origin torque 50 %, brake delay 400 ms
`define SPC_RST_PARAM 32'h0000_0020
`define SPC_RST_LIMIT 32'h1388_1388
`define SPC_RST_CURRENT 32'h0032_005a
`define SPC_RST_BRAKE 32'h0000_0190

// Interrupt bits
`define SPC_IRQ_OVF 0
`define SPC_IRQ_TRK 1
`define SPC_IRQ_SON 2

`define SPC_ORG_STOPPER 4'h3
`define SPC_RUN_STEP 10'h00a
`define SPC_BOOST_STEP 10'h032

// Timing
`define SPC_CLK_PERIOD_NS 100
`define SPC_NS_PER_MS 1000000
`define SPC_SON_FAST_MS 16'h0190
`define SPC_SON_SAFE_MS 16'h09c4

`endif

// *** verilog/spc_pkg.sv ***
// Types for the servo protection and current-limit block
// Assumes spc_defines.svh is on the include path
package spc_pkg;
  `include "spc_defines.svh"

  typedef enum logic [1:0] {
    SPC_OFF = 2'b00,
    SPC_ENGAGE = 2'b01,
    SPC_ON = 2'b11,
    SPC_ALARM = 2'b10
  } spc_state_t;

  typedef struct packed {
    logic moving;
    logic ramping;
    logic homing;
  } spc_motion_t;

  typedef struct packed {
    logic servo_on;
    logic current_en;
    logic brake_release;
    logic alarm;
    logic [9:0] current_pct;
  } spc_drive_t;
endpackage : spc_pkg

// *** verilog/spc_ms_timer.sv ***
// Millisecond down-counter: loads on start, counts on the shared ms tick
// Assumes tick is a one-cycle pulse from the same clock
`timescale 1ns/100ps
module spc_ms_timer
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic tick,
  input wire logic [15:0] load_ms,
  output logic done
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic run_reg;
  logic run_next;

  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    if (start) begin
      cnt_next = load_ms;
      run_next = 1'b1;
    end else if (run_reg && tick && cnt_reg != 16'h0000) begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      run_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end

  // Zero load means done at once; done holds until the next start
  assign done = run_reg && !start && cnt_reg == 16'h0000;
endmodule : spc_ms_timer

// *** verilog/spc_top.sv ***
// Servo supervision: error alarms, servo-on sequence, brake delay, current limits
// Assumes motion status and errors come from logic on clk; APB slave, zero wait
//
// Summary of operation
// - origin torque limit only for origin method 3
// - standstill error over limit: alarm, current off
// - count format 0 signed, 1 positive only
// - servo-on takes 400 ms, safe mode ~2.5 s
// - brake output delayed by programmed milliseconds
// - run current limit while moving, 10 % steps
// - stop current limit at standstill, 10 % steps
// - boost current limit while ramping, 50 % steps
// - running error over tracking limit: alarm, off
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "spc_defines.svh"
module spc_top
  import spc_pkg::*;
#(
  parameter int CYC_PER_MS = `SPC_NS_PER_MS / `SPC_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire spc_motion_t motion,
  input wire logic signed [31:0] pos_err,
  input wire logic signed [31:0] position,
  output spc_drive_t drive,
  output logic [31:0] position_out,
  output logic irq
);
  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    logic [31:0] m;
    m = v[31] ? 32'(-v) : 32'(v);
    // Most negative value saturates rather than wrapping negative
    abs32 = m[31] ? 32'h7fff_ffff : m;
  endfunction : abs32

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    addr_is = (a == b);
  endfunction : addr_is

  // Register file
  logic [31:0] param_reg, param_next;
  logic [31:0] limit_reg, limit_next;
  logic [31:0] current_reg, current_next;
  logic [31:0] brake_reg, brake_next;
  logic [2:0] irq_stat_reg, irq_stat_next;
  logic [2:0] irq_en_reg, irq_en_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [31:0] pos_reg, pos_next;

  logic wr_en;
  logic setup;
  logic mapped;
  logic [2:0] irq_clr;
  logic [2:0] irq_set;

  logic [3:0] org_method;
  logic fmt_pos_only;
  logic son_fast;
  logic son_req;
  logic [15:0] ovf_limit;
  logic [15:0] trk_limit;
  logic [3:0] run_cur;
  logic [3:0] stop_cur;
  logic [3:0] boost_cur;
  logic [6:0] org_ratio;

  assign org_method = param_reg[`SPC_F_ORG_LSB +: 4];
  assign fmt_pos_only = param_reg[`SPC_F_FMT];
  assign son_fast = param_reg[`SPC_F_SON_METHOD];
  assign son_req = param_reg[`SPC_F_SON_REQ];
  assign ovf_limit = limit_reg[`SPC_F_OVF_LSB +: 16];
  assign trk_limit = limit_reg[`SPC_F_TRK_LSB +: 16];
  assign run_cur = current_reg[`SPC_F_RUN_LSB +: 4];
  assign stop_cur = current_reg[`SPC_F_STOP_LSB +: 4];
  assign boost_cur = current_reg[`SPC_F_BOOST_LSB +: 4];
  assign org_ratio = current_reg[`SPC_F_RATIO_LSB +: 7];

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign mapped = addr_is(paddr, `SPC_ADDR_PARAM) || addr_is(paddr, `SPC_ADDR_LIMIT) ||
                  addr_is(paddr, `SPC_ADDR_CURRENT) || addr_is(paddr, `SPC_ADDR_BRAKE) ||
                  addr_is(paddr, `SPC_ADDR_STATUS) || addr_is(paddr, `SPC_ADDR_POSITION) ||
                  addr_is(paddr, `SPC_ADDR_IRQ_STAT) || addr_is(paddr, `SPC_ADDR_IRQ_CLR) ||
                  addr_is(paddr, `SPC_ADDR_IRQ_EN);
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  assign irq_clr = (wr_en && addr_is(paddr, `SPC_ADDR_IRQ_CLR)) ? pwdata[2:0] : 3'h0;

  // Servo sequence state
  spc_state_t state_reg, state_next;
  logic [13:0] pre_reg, pre_next;
  logic ms_tick;
  logic enter_engage;
  logic seq_done;
  logic brake_done;
  logic [31:0] err_mag;
  logic ovf_trip;
  logic trk_trip;

  assign err_mag = abs32(pos_err);
  assign ovf_trip = (state_reg == SPC_ON) && !motion.moving &&
                    err_mag > {16'h0000, ovf_limit};
  assign trk_trip = (state_reg == SPC_ON) && motion.moving &&
                    err_mag > {16'h0000, trk_limit};
  assign enter_engage = (state_reg == SPC_OFF) && son_req;
  assign ms_tick = (pre_reg == 14'(CYC_PER_MS - 1));
  assign irq_set = {(state_reg == SPC_ENGAGE) && seq_done, trk_trip, ovf_trip};

  always_comb begin
    param_next = param_reg;
    limit_next = limit_reg;
    current_next = current_reg;
    brake_next = brake_reg;
    irq_en_next = irq_en_reg;
    prdata_next = prdata_reg;
    // Set wins over a clear in the same cycle
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    if (wr_en) begin
      case (paddr)
        `SPC_ADDR_PARAM: param_next = pwdata & 32'h0000_013f;
        `SPC_ADDR_LIMIT: limit_next = pwdata;
        `SPC_ADDR_CURRENT: current_next = pwdata & 32'h007f_0fff;
        `SPC_ADDR_BRAKE: brake_next = {16'h0000, pwdata[15:0]};
        `SPC_ADDR_IRQ_EN: irq_en_next = pwdata[2:0];
        default: ;
      endcase
    end
    // Read data is captured in the setup cycle so it comes from a flip-flop
    if (setup && !pwrite) begin
      case (paddr)
        `SPC_ADDR_PARAM: prdata_next = param_reg;
        `SPC_ADDR_LIMIT: prdata_next = limit_reg;
        `SPC_ADDR_CURRENT: prdata_next = current_reg;
        `SPC_ADDR_BRAKE: prdata_next = brake_reg;
        `SPC_ADDR_STATUS: prdata_next = {26'h0, brake_done, seq_done, drive.alarm,
                                         drive.servo_on, state_reg};
        `SPC_ADDR_POSITION: prdata_next = pos_reg;
        `SPC_ADDR_IRQ_STAT: prdata_next = {29'h0, irq_stat_reg};
        `SPC_ADDR_IRQ_EN: prdata_next = {29'h0, irq_en_reg};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      param_reg <= `SPC_RST_PARAM;
      limit_reg <= `SPC_RST_LIMIT;
      current_reg <= `SPC_RST_CURRENT;
      brake_reg <= `SPC_RST_BRAKE;
      irq_stat_reg <= 3'h0;
      irq_en_reg <= 3'h0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      param_reg <= param_next;
      limit_reg <= limit_next;
      current_reg <= current_next;
      brake_reg <= brake_next;
      irq_stat_reg <= irq_stat_next;
      irq_en_reg <= irq_en_next;
      prdata_reg <= prdata_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  spc_ms_timer u_seq_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(enter_engage),
    .tick(ms_tick),
    .load_ms(son_fast ? `SPC_SON_FAST_MS : `SPC_SON_SAFE_MS),
    .done(seq_done)
  );

  spc_ms_timer u_brake_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(enter_engage),
    .tick(ms_tick),
    .load_ms(brake_reg[15:0]),
    .done(brake_done)
  );

  always_comb begin
    pre_next = ms_tick ? 14'h0000 : pre_reg + 14'h0001;
    state_next = state_reg;
    case (state_reg)
      SPC_OFF: begin
        if (son_req) begin
          state_next = SPC_ENGAGE;
        end
      end
      SPC_ENGAGE: begin
        if (!son_req) begin
          state_next = SPC_OFF;
        end else if (seq_done) begin
          state_next = SPC_ON;
        end
      end
      SPC_ON: begin
        if (ovf_trip || trk_trip) begin
          state_next = SPC_ALARM;
        end else if (!son_req) begin
          state_next = SPC_OFF;
        end
      end
      // Alarm holds until software drops the servo-on request
      SPC_ALARM: begin
        if (!son_req) begin
          state_next = SPC_OFF;
        end
      end
      default: state_next = SPC_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SPC_OFF;
      pre_reg <= 14'h0000;
    end else begin
      state_reg <= state_next;
      pre_reg <= pre_next;
    end
  end

  // Drive outputs and current limit selection
  spc_drive_t drive_reg, drive_next;
  logic sel_org, sel_boost, sel_run, sel_stop;
  logic powered;

  assign powered = (state_reg == SPC_ENGAGE) || (state_reg == SPC_ON);
  assign sel_org = powered && motion.homing && org_method == `SPC_ORG_STOPPER;
  assign sel_boost = powered && !sel_org && motion.ramping && boost_cur != 4'h0;
  assign sel_run = powered && !sel_org && !sel_boost && motion.moving;
  assign sel_stop = powered && !sel_org && !sel_boost && !sel_run;

  always_comb begin
    drive_next.servo_on = (state_reg == SPC_ON);
    drive_next.current_en = powered;
    drive_next.alarm = (state_reg == SPC_ALARM);
    drive_next.brake_release = powered && brake_done;
    drive_next.current_pct = 10'h000;
    if (sel_org) begin
      drive_next.current_pct = {3'h0, org_ratio};
    end else if (sel_boost) begin
      drive_next.current_pct = 10'({6'h00, boost_cur} * `SPC_BOOST_STEP);
    end else if (sel_run) begin
      drive_next.current_pct = 10'({6'h00, run_cur} * `SPC_RUN_STEP);
    end else if (sel_stop) begin
      drive_next.current_pct = 10'({6'h00, stop_cur} * `SPC_RUN_STEP);
    end
    // Positive-only format shows the magnitude, meant for one-way travel
    pos_next = fmt_pos_only ? abs32(position) : 32'(position);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_reg <= '0;
      pos_reg <= 32'h0000_0000;
    end else begin
      drive_reg <= drive_next;
      pos_reg <= pos_next;
    end
  end

  assign drive = drive_reg;
  assign position_out = pos_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  standstill_trip_a: assert property (
    (state_reg == SPC_ON && !motion.moving && err_mag > {16'h0000, ovf_limit})
    |=> state_reg == SPC_ALARM ##1 !drive.current_en && !drive.servo_on && drive.alarm)
    else $error("standstill error did not trip alarm");
  tracking_trip_a: assert property (
    (state_reg == SPC_ON && motion.moving && err_mag > {16'h0000, trk_limit})
    |=> state_reg == SPC_ALARM ##1 !drive.current_en)
    else $error("tracking error did not trip alarm");
  origin_torque_a: assert property (
    (powered && motion.homing && org_method == `SPC_ORG_STOPPER)
    |=> drive.current_pct == {3'h0, $past(org_ratio)})
    else $error("origin torque limit not applied");
  run_current_a: assert property (
    (powered && !motion.homing && !motion.ramping && motion.moving)
    |=> drive.current_pct == {6'h00, $past(run_cur)} * 10'h00a)
    else $error("run current limit wrong");
  stop_current_a: assert property (
    (powered && !motion.homing && !motion.ramping && !motion.moving)
    |=> drive.current_pct == {6'h00, $past(stop_cur)} * 10'h00a)
    else $error("stop current limit wrong");
  boost_current_a: assert property (
    (powered && !motion.homing && motion.ramping && boost_cur != 4'h0)
    |=> drive.current_pct == {6'h00, $past(boost_cur)} * 10'h032)
    else $error("boost current limit wrong");
  one_limit_a: assert property (
    $onehot0({sel_org, sel_boost, sel_run, sel_stop}) && (powered == (sel_org || sel_boost ||
    sel_run || sel_stop)))
    else $error("current limit selection not unique");
  count_format_a: assert property (
    fmt_pos_only |=> !position_out[31])
    else $error("positive-only position went negative");
  servo_wait_a: assert property (
    (state_reg == SPC_ENGAGE && !seq_done) |=> state_reg != SPC_ON)
    else $error("servo on before sequence time");
  brake_delay_a: assert property (
    $rose(drive.brake_release) |-> $past(brake_done) && $past(powered))
    else $error("brake released before its delay");
endmodule : spc_top

// *** verification/spc_motor_model.sv ***
// Behavioural motor and encoder beside the supervision block
// Assumes the bench commands motion and error; shares clk and rst_n
`timescale 1ns/100ps
module spc_motor_model
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire spc_drive_t drive,
  input wire logic cmd_move,
  input wire logic cmd_ramp,
  input wire logic cmd_home,
  input wire logic signed [31:0] err_set,
  output spc_motion_t motion,
  output logic signed [31:0] pos_err,
  output logic signed [31:0] position
);
  // A motor with no current cannot move, whatever is commanded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      motion <= '0;
      position <= '0;
    end else begin
      motion.moving <= cmd_move & drive.current_en;
      motion.ramping <= cmd_ramp & drive.current_en;
      motion.homing <= cmd_home & drive.current_en;
      if (motion.moving) begin
        position <= position - 32'sh1;
      end
    end
  end
  assign pos_err = err_set;
endmodule : spc_motor_model

// *** verification/spc_top_tb.sv ***
// Self-checking bench for the servo supervision block
// Assumes the design and spc_motor_model are compiled first
`timescale 1ns/100ps
module spc_top_tb
  import spc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, position_out, rd;
  logic pready, pslverr, irq, er;
  logic mv = 1'b0;
  logic rp = 1'b0;
  logic hm = 1'b0;
  logic signed [31:0] pe = 32'sh0;
  logic signed [31:0] pos_err, position;
  spc_motion_t motion;
  spc_drive_t drive;
  int err_count = 0;
  int num_checks = 0;

  always #50 clk = ~clk;

  spc_top #(.CYC_PER_MS(10)) spc_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motion(motion), .pos_err(pos_err),
    .position(position), .drive(drive), .position_out(position_out), .irq(irq));
  spc_motor_model spc_motor_model_inst (.clk(clk), .rst_n(rst_n), .drive(drive),
    .cmd_move(mv), .cmd_ramp(rp), .cmd_home(hm), .err_set(pe), .motion(motion),
    .pos_err(pos_err), .position(position));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : rw

  // Brake delay is 20 ms; the first ms tick may come up to 1 ms early
  task automatic son(input int ms);
    int c;
    int b;
    c = 0;
    b = 0;
    while (drive.servo_on !== 1'b1 && c < 30000) begin
      @(posedge clk);
      c++;
      if (b == 0 && drive.brake_release === 1'b1) b = c;
    end
    chk(32'(c >= ms * 10 - 15 && c <= ms * 10 + 10), 32'h1);
    chk(32'(b >= 185 && b <= 205), 32'h1);
  endtask : son

  task automatic cur(input logic m, input logic r, input logic h, input logic [9:0] exp);
    mv <= m;
    rp <= r;
    hm <= h;
    repeat (3) @(posedge clk);
    chk({22'h0, drive.current_pct}, {22'h0, exp});
  endtask : cur

  task automatic t_reset();
    rw(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h20);
    rw(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1388_1388);
    rw(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0032_005a);
    rw(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h190);
    rw(1'b0, 8'h24, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask : t_reset

  task automatic t_currents();
    rw(1'b1, 8'h08, 32'h0037_0273);
    cur(1'b0, 1'b0, 1'b0, 10'h046);
    cur(1'b1, 1'b0, 1'b0, 10'h01e);
    cur(1'b1, 1'b1, 1'b0, 10'h064);
    cur(1'b0, 1'b0, 1'b1, 10'h046);
    rw(1'b1, 8'h00, 32'h123);
    cur(1'b1, 1'b1, 1'b1, 10'h037);
    rw(1'b1, 8'h00, 32'h120);
    rw(1'b1, 8'h08, 32'h0037_0073);
    cur(1'b1, 1'b1, 1'b0, 10'h01e);
    cur(1'b0, 1'b0, 1'b0, 10'h046);
  endtask : t_currents

  // Servo-on event is cleared first so that irq can only come from the trip
  task automatic t_standstill();
    rw(1'b1, 8'h1c, 32'h7);
    pe <= 32'sd5000;
    repeat (3) @(posedge clk);
    chk({30'h0, drive.alarm, irq}, 32'h0);
    pe <= 32'sd5001;
    repeat (3) @(posedge clk);
    chk({drive.servo_on, drive.current_en, drive.alarm, irq}, 32'h3);
    rw(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h3a);
    rw(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h1);
    rw(1'b1, 8'h1c, 32'h7);
    rw(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], irq}, 32'h0);
    pe <= 32'sh0;
    rw(1'b1, 8'h00, 32'h20);
  endtask : t_standstill

  task automatic t_track();
    rw(1'b1, 8'h04, 32'h0064_1388);
    rw(1'b1, 8'h00, 32'h120);
    son(400);
    mv <= 1'b1;
    pe <= -32'sd100;
    repeat (3) @(posedge clk);
    chk({31'h0, drive.alarm}, 32'h0);
    pe <= -32'sd101;
    repeat (3) @(posedge clk);
    chk({drive.servo_on, drive.current_en, drive.alarm}, 32'h1);
    rw(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h6);
    mv <= 1'b0;
    pe <= 32'sh0;
    rw(1'b1, 8'h1c, 32'h7);
    rw(1'b1, 8'h00, 32'h20);
  endtask : t_track

  // Motor has stopped, so its position is stable while format changes
  task automatic t_format();
    repeat (3) @(posedge clk);
    chk(position_out, position);
    rw(1'b1, 8'h00, 32'h30);
    repeat (2) @(posedge clk);
    chk(position_out, -position);
    rw(1'b0, 8'h14, 32'h0);
    chk(rd, -position);
  endtask : t_format

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    rw(1'b1, 8'h0c, 32'h14);
    rw(1'b1, 8'h20, 32'h7);
    rw(1'b1, 8'h00, 32'h120);
    son(400);
    t_currents();
    t_standstill();
    t_track();
    t_format();
    rw(1'b1, 8'h00, 32'h100);
    son(2500);
    wrap_up();
  end

  // Whole run is about 33000 cycles
  initial begin
    #(45000 * 100);
    err_count++;
    wrap_up();
  end
endmodule : spc_top_tb
